/* File: pcmr_pkg.sv */
// shared constants for the voice receive event reporter
package pcmr_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PAYLOAD = 8'h04;
	localparam logic [7:0] OFS_LEADS = 8'h08;
	localparam logic [7:0] OFS_INIT_LEAD = 8'h0C;
	localparam logic [7:0] OFS_STRUCT = 8'h10;
	localparam logic [7:0] OFS_SLIP = 8'h14;
	localparam logic [7:0] OFS_PKT_CNT = 8'h18;
	localparam logic [7:0] OFS_DELTA = 8'h1C;
	// control register bit positions
	localparam int CTRL_MON_REQ = 0;
	localparam int CTRL_SLIP_REQ = 1;
	localparam int CTRL_CHAN_INIT = 2;
	localparam int CTRL_COMMON_INIT = 3;
	// reset values
	localparam logic [15:0] RST_MAX_EXP = 16'h0000;
	localparam logic [15:0] RST_MAX_USED = 16'h0000;
	localparam logic [15:0] RST_UNDER_LEAD = 16'h0008;
	localparam logic [15:0] RST_OVER_LEAD = 16'h0000;
	localparam logic [15:0] RST_INIT_LEAD = 16'h0000;
	// report flag positions
	localparam int F_LATE = 0;
	localparam int F_UNDER = 1;
	localparam int F_OVER = 2;
	localparam int F_CHAN_INIT = 3;
	localparam int F_COMMON_INIT = 4;
	localparam int F_MON_DONE = 5;
	localparam int F_SLIP_DONE = 6;
	localparam int F_LOST = 7;
	localparam int F_DIV_ERR = 8;
	localparam int F_LONGER = 9;
	localparam int F_OVERSIZE = 10;
	localparam int F_EMPTY = 11;
	localparam int F_XDELAY = 12;
	localparam int FLAG_W = 13;
	// length limits, in frames
	localparam logic [14:0] MAX_FRAMES = 15'h07FF;
	// bits in one payload byte, as a shift
	localparam int BYTE_SHIFT = 3;
	// packet handling states, gray along the path except the EVAL to IDLE skip
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DIV = 2'b01,
		ST_EVAL = 2'b11,
		ST_REP = 2'b10
	} pcmr_state_t;
endpackage

/* File: pcmr_len_div.sv */
`timescale 1ns/1ps
// serial restoring divider: payload bits over channels times sample bits
module pcmr_len_div #(
	parameter int BW = 11
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// request
	input wire logic start,
	input wire logic [BW-1:0] bytes,
	input wire logic [7:0] chans,
	input wire logic [3:0] bps,
	// answer
	output logic done,
	output logic [BW+2:0] quot,
	output logic rem_nz
);
	localparam int QW = BW + 3;
	localparam logic [4:0] STEPS = 5'(QW);
	logic [QW-1:0] dvd_ff; // dividend, shifts into quotient
	logic [11:0] dvs_ff; // divisor
	logic [11:0] rem_ff; // partial remainder
	logic [4:0] cnt_ff; // steps left
	logic done_ff;
	logic [12:0] trial; // remainder with next dividend bit
	logic fits;

	// next trial subtraction
	always_comb begin
		trial = {rem_ff, dvd_ff[QW-1]};
		fits = trial >= {1'b0, dvs_ff};
	end

	// one quotient bit per clock
	always_ff @(posedge mclk) begin
		if (rst) begin
			dvd_ff <= '0;
			dvs_ff <= '0;
			rem_ff <= '0;
			cnt_ff <= '0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (start) begin
				// payload bytes times eight
				dvd_ff <= {bytes, 3'b000};
				dvs_ff <= {4'h0, chans} * {8'h00, bps};
				rem_ff <= '0;
				cnt_ff <= STEPS;
			end else if (cnt_ff != 5'h00) begin
				if (fits) begin
					rem_ff <= 12'(trial - {1'b0, dvs_ff});
				end else begin
					rem_ff <= trial[11:0];
				end
				dvd_ff <= {dvd_ff[QW-2:0], fits};
				cnt_ff <= cnt_ff - 5'h01;
				done_ff <= cnt_ff == 5'h01;
			end
		end
	end

	// zero divisor counts as not divisible
	assign done = done_ff;
	assign quot = dvd_ff;
	assign rem_nz = (rem_ff != 12'h000) || (dvs_ff == 12'h000);
endmodule

/* File: pcmr_event_report.sv */
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module pcmr_event_report #(
	parameter int BW = 11,
	parameter int PW = 12
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// received packet
	input wire logic pkt_valid,
	output logic pkt_ready,
	input wire logic [31:0] pkt_remote_ts,
	input wire logic [BW-1:0] pkt_bytes,
	input wire logic [7:0] pkt_chans,
	input wire logic [3:0] pkt_bps,
	// playout side
	input wire logic [31:0] tdm_ts,
	input wire logic [PW-1:0] tdm_rd_ptr,
	input wire logic xdelay_det,
	// write pointer reload
	output logic wp_load,
	output logic [PW-1:0] wp_value,
	output logic pkt_discard,
	// event report
	output logic rep_valid,
	input wire logic rep_ready,
	output logic [pcmr_pkg::FLAG_W-1:0] rep_flags,
	output logic [31:0] rep_struct_addr,
	output logic [31:0] rep_lost,
	output logic [31:0] rep_remote_ts,
	output logic [31:0] rep_local_ts
);
	// software state
	logic mon_req_ff; // monitor reset request
	logic slip_req_ff; // slip offset reset request
	logic chan_init_ff; // channel has seen a packet
	logic common_init_ff; // shared structure has seen a packet
	logic [15:0] max_exp_ff; // max expected payload, samples
	logic [15:0] max_used_ff; // used window, samples
	logic [15:0] under_lead_ff;
	logic [15:0] over_lead_ff;
	logic [15:0] init_lead_ff;
	logic [31:0] struct_ff; // channel structure base address
	// hardware state
	logic [31:0] slip_ofs_ff; // total slip offset delta
	logic [31:0] pkt_cnt_ff; // received packet count
	logic [15:0] min_dlt_ff; // smallest lead seen
	logic [15:0] max_dlt_ff; // largest lead seen
	logic [31:0] last_ts_ff; // last remote timestamp
	logic [14:0] last_ns_ff; // last sample count
	// packet latches
	logic [31:0] lat_rts_ff;
	logic [31:0] lat_lts_ff;
	logic [PW-1:0] lat_rd_ff;
	pcmr_pkg::pcmr_state_t st_ff;
	pcmr_pkg::pcmr_state_t nxt_st;
	// bus
	logic ack_ff;
	logic [31:0] rdat_ff;
	logic wr_en; // write takes effect at the ack edge
	logic [31:0] wmask;
	// divider
	logic div_done;
	logic [BW+2:0] nsamp;
	logic rem_nz;
	// evaluation terms
	logic take;
	logic signed [32:0] lead;
	logic signed [32:0] pad;
	logic late_c, under_c, over_c, len_bad;
	logic [31:0] lost_c;
	logic [pcmr_pkg::FLAG_W-1:0] flags_c;
	logic [15:0] lead_sel; // lead used for a reload
	logic reload;

	// sample count and length check
	pcmr_len_div #(.BW(BW)) pcmr_len_div_inst (
		.mclk(mclk),
		.rst(rst),
		.start(take),
		.bytes(pkt_bytes),
		.chans(pkt_chans),
		.bps(pkt_bps),
		.done(div_done),
		.quot(nsamp),
		.rem_nz(rem_nz)
	);

	// byte lane mask from select
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
		end
	end

	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
	assign take = pkt_valid && pkt_ready;
	assign pkt_ready = st_ff == pcmr_pkg::ST_IDLE;

	// ack one cycle after strobe, dropped after one cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
		end
	end

	// read data, unmapped offsets read zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdat_ff <= '0;
		end else if (wb_cyc_i && wb_stb_i && !ack_ff) begin
			case (wb_adr_i)
				pcmr_pkg::OFS_CTRL: begin
					rdat_ff <= {28'h0000000, common_init_ff, chan_init_ff,
						slip_req_ff, mon_req_ff};
				end
				pcmr_pkg::OFS_PAYLOAD: rdat_ff <= {max_used_ff, max_exp_ff};
				pcmr_pkg::OFS_LEADS: rdat_ff <= {over_lead_ff, under_lead_ff};
				pcmr_pkg::OFS_INIT_LEAD: rdat_ff <= {16'h0000, init_lead_ff};
				pcmr_pkg::OFS_STRUCT: rdat_ff <= struct_ff;
				pcmr_pkg::OFS_SLIP: rdat_ff <= slip_ofs_ff;
				pcmr_pkg::OFS_PKT_CNT: rdat_ff <= pkt_cnt_ff;
				pcmr_pkg::OFS_DELTA: rdat_ff <= {max_dlt_ff, min_dlt_ff};
				default: rdat_ff <= '0;
			endcase
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	// configuration words
	always_ff @(posedge mclk) begin
		if (rst) begin
			max_exp_ff <= pcmr_pkg::RST_MAX_EXP;
			max_used_ff <= pcmr_pkg::RST_MAX_USED;
			under_lead_ff <= pcmr_pkg::RST_UNDER_LEAD;
			over_lead_ff <= pcmr_pkg::RST_OVER_LEAD;
			init_lead_ff <= pcmr_pkg::RST_INIT_LEAD;
			struct_ff <= '0;
		end else if (wr_en) begin
			case (wb_adr_i)
				pcmr_pkg::OFS_PAYLOAD: begin
					{max_used_ff, max_exp_ff} <= (wb_dat_i & wmask) |
						({max_used_ff, max_exp_ff} & ~wmask);
				end
				pcmr_pkg::OFS_LEADS: begin
					{over_lead_ff, under_lead_ff} <= (wb_dat_i & wmask) |
						({over_lead_ff, under_lead_ff} & ~wmask);
				end
				pcmr_pkg::OFS_INIT_LEAD: begin
					if (wb_sel_i[0]) init_lead_ff[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1]) init_lead_ff[15:8] <= wb_dat_i[15:8];
				end
				pcmr_pkg::OFS_STRUCT: begin
					struct_ff <= (wb_dat_i & wmask) | (struct_ff & ~wmask);
				end
				default: begin
				end
			endcase
		end
	end

	// packet state machine
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			pcmr_pkg::ST_IDLE: if (take) nxt_st = pcmr_pkg::ST_DIV;
			pcmr_pkg::ST_DIV: if (div_done) nxt_st = pcmr_pkg::ST_EVAL;
			pcmr_pkg::ST_EVAL: begin
				// only packets with something to say are reported
				nxt_st = (flags_c != '0) ? pcmr_pkg::ST_REP :
					pcmr_pkg::ST_IDLE;
			end
			pcmr_pkg::ST_REP: if (rep_ready) nxt_st = pcmr_pkg::ST_IDLE;
			default: nxt_st = pcmr_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_ff <= pcmr_pkg::ST_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// latch arrival time stamps and read pointer
	always_ff @(posedge mclk) begin
		if (rst) begin
			lat_rts_ff <= '0;
			lat_lts_ff <= '0;
			lat_rd_ff <= '0;
		end else if (take) begin
			lat_rts_ff <= pkt_remote_ts;
			lat_lts_ff <= tdm_ts;
			lat_rd_ff <= tdm_rd_ptr;
		end
	end

	// classification of the packet
	always_comb begin
		lead = 33'($signed(lat_rts_ff - lat_lts_ff));
		pad = ({1'b0, max_exp_ff} > {3'b000, nsamp}) ?
			33'({1'b0, max_exp_ff} - {3'b000, nsamp}) : 33'sd0;
		late_c = lead < 33'sd0;
		under_c = lead < pad;
		over_c = (lead + $signed(33'({18'h00000, nsamp})) - 33'sd1) >
			$signed(33'({17'h00000, max_used_ff}));
		lost_c = '0;
		if (chan_init_ff &&
			lat_rts_ff > last_ts_ff + {17'h00000, last_ns_ff}) begin
			lost_c = lat_rts_ff - last_ts_ff -
				{17'h00000, last_ns_ff};
		end
		flags_c = '0;
		flags_c[pcmr_pkg::F_DIV_ERR] = rem_nz;
		flags_c[pcmr_pkg::F_OVERSIZE] = nsamp > pcmr_pkg::MAX_FRAMES;
		flags_c[pcmr_pkg::F_EMPTY] = nsamp == 15'h0000;
		len_bad = flags_c[pcmr_pkg::F_DIV_ERR] |
			flags_c[pcmr_pkg::F_OVERSIZE] | flags_c[pcmr_pkg::F_EMPTY];
		flags_c[pcmr_pkg::F_LONGER] =
			{3'b000, nsamp} > {1'b0, max_exp_ff};
		flags_c[pcmr_pkg::F_XDELAY] = xdelay_det;
		if (!len_bad) begin
			flags_c[pcmr_pkg::F_CHAN_INIT] = !chan_init_ff;
			flags_c[pcmr_pkg::F_COMMON_INIT] = !common_init_ff;
			flags_c[pcmr_pkg::F_MON_DONE] = mon_req_ff;
			flags_c[pcmr_pkg::F_SLIP_DONE] = slip_req_ff;
			flags_c[pcmr_pkg::F_LOST] = lost_c != '0;
			if (chan_init_ff) begin
				flags_c[pcmr_pkg::F_LATE] = late_c;
				flags_c[pcmr_pkg::F_UNDER] = under_c;
				flags_c[pcmr_pkg::F_OVER] = !under_c && over_c;
			end
		end
		// first packet uses init lead, then underrun before overrun
		reload = (st_ff == pcmr_pkg::ST_EVAL) && !len_bad &&
			(!chan_init_ff || under_c || over_c);
		if (!chan_init_ff) begin
			lead_sel = init_lead_ff;
		end else if (under_c) begin
			lead_sel = under_lead_ff;
		end else begin
			lead_sel = over_lead_ff;
		end
	end

	// write pointer reload and discard pulses
	always_ff @(posedge mclk) begin
		if (rst) begin
			wp_load <= 1'b0;
			wp_value <= '0;
			pkt_discard <= 1'b0;
		end else begin
			wp_load <= reload;
			pkt_discard <= (st_ff == pcmr_pkg::ST_EVAL) && len_bad;
			if (reload) begin
				wp_value <= PW'(lat_rd_ff + PW'(lead_sel));
			end
		end
	end

	// control bits: hardware sets win, software sets win over clears
	always_ff @(posedge mclk) begin
		if (rst) begin
			mon_req_ff <= 1'b0;
			slip_req_ff <= 1'b0;
			chan_init_ff <= 1'b0;
			common_init_ff <= 1'b0;
		end else begin
			if (wr_en && wb_adr_i == pcmr_pkg::OFS_CTRL && wb_sel_i[0]) begin
				chan_init_ff <= wb_dat_i[pcmr_pkg::CTRL_CHAN_INIT];
				common_init_ff <= wb_dat_i[pcmr_pkg::CTRL_COMMON_INIT];
			end
			if (st_ff == pcmr_pkg::ST_EVAL && !len_bad) begin
				chan_init_ff <= 1'b1;
				common_init_ff <= 1'b1;
				mon_req_ff <= 1'b0;
				slip_req_ff <= 1'b0;
			end
			if (wr_en && wb_adr_i == pcmr_pkg::OFS_CTRL && wb_sel_i[0]) begin
				if (wb_dat_i[pcmr_pkg::CTRL_MON_REQ]) mon_req_ff <= 1'b1;
				if (wb_dat_i[pcmr_pkg::CTRL_SLIP_REQ]) slip_req_ff <= 1'b1;
			end
		end
	end

	// channel history, counters and monitoring window
	always_ff @(posedge mclk) begin
		if (rst) begin
			slip_ofs_ff <= '0;
			pkt_cnt_ff <= '0;
			min_dlt_ff <= '0;
			max_dlt_ff <= '0;
			last_ts_ff <= '0;
			last_ns_ff <= '0;
		end else if (st_ff == pcmr_pkg::ST_EVAL && !len_bad) begin
			pkt_cnt_ff <= pkt_cnt_ff + 32'h00000001;
			last_ts_ff <= lat_rts_ff;
			last_ns_ff <= 15'(nsamp);
			if (mon_req_ff || !chan_init_ff) begin
				// new monitoring period starts from this packet
				min_dlt_ff <= lead[15:0];
				max_dlt_ff <= lead[15:0];
			end else begin
				if ($signed(lead[15:0]) < $signed(min_dlt_ff)) begin
					min_dlt_ff <= lead[15:0];
				end
				if ($signed(lead[15:0]) > $signed(max_dlt_ff)) begin
					max_dlt_ff <= lead[15:0];
				end
			end
			if (slip_req_ff) begin
				slip_ofs_ff <= '0;
			end else if (chan_init_ff && (under_c || over_c)) begin
				slip_ofs_ff <= slip_ofs_ff + {16'h0000, lead_sel} -
					lead[31:0];
			end
		end
	end

	// event report, held until taken
	always_ff @(posedge mclk) begin
		if (rst) begin
			rep_valid <= 1'b0;
			rep_flags <= '0;
			rep_struct_addr <= '0;
			rep_lost <= '0;
			rep_remote_ts <= '0;
			rep_local_ts <= '0;
		end else if (st_ff == pcmr_pkg::ST_EVAL) begin
			rep_valid <= flags_c != '0;
			rep_flags <= flags_c;
			rep_struct_addr <= struct_ff;
			rep_lost <= len_bad ? 32'h00000000 : lost_c;
			rep_remote_ts <= lat_rts_ff;
			rep_local_ts <= lat_lts_ff;
		end else if (rep_ready) begin
			rep_valid <= 1'b0;
		end
	end

	// checks
	sequence s_eval_good;
		st_ff == pcmr_pkg::ST_EVAL && !len_bad;
	endsequence

	a_lost_matches: assert property (@(posedge mclk) disable iff (rst)
		rep_valid |-> rep_flags[pcmr_pkg::F_LOST] == (rep_lost != 32'h0))
		else $error("lost flag disagrees with lost count");
	a_report_flags: assert property (@(posedge mclk) disable iff (rst)
		rep_valid |-> rep_flags != '0)
		else $error("report queued with no flag set");
	a_late_seen: assert property (@(posedge mclk) disable iff (rst)
		s_eval_good ##0 (chan_init_ff && late_c) |=>
		rep_valid && rep_flags[pcmr_pkg::F_LATE])
		else $error("late packet not reported");
	a_oversize_len: assert property (@(posedge mclk) disable iff (rst)
		st_ff == pcmr_pkg::ST_EVAL && nsamp > pcmr_pkg::MAX_FRAMES |=>
		rep_flags[pcmr_pkg::F_OVERSIZE] && pkt_discard)
		else $error("oversize packet not flagged");
	a_empty_len: assert property (@(posedge mclk) disable iff (rst)
		st_ff == pcmr_pkg::ST_EVAL && nsamp == 15'h0000 |=>
		rep_flags[pcmr_pkg::F_EMPTY] && !wp_load)
		else $error("empty packet not flagged");
	a_mon_cleared: assert property (@(posedge mclk) disable iff (rst)
		s_eval_good ##0 (mon_req_ff && !wr_en) |=>
		!mon_req_ff && rep_flags[pcmr_pkg::F_MON_DONE] &&
		min_dlt_ff == max_dlt_ff)
		else $error("monitor reset request not completed");
	a_under_ptr: assert property (@(posedge mclk) disable iff (rst)
		s_eval_good ##0 (chan_init_ff && under_c) |=>
		wp_load && wp_value == PW'($past(lat_rd_ff) +
		PW'($past(under_lead_ff))))
		else $error("underrun reload value wrong");
	a_over_ptr: assert property (@(posedge mclk) disable iff (rst)
		s_eval_good ##0 (chan_init_ff && !under_c && over_c) |=>
		wp_load && wp_value == PW'($past(lat_rd_ff) +
		PW'($past(over_lead_ff))))
		else $error("overrun reload value wrong");
	a_take_to_eval: assert property (@(posedge mclk) disable iff (rst)
		take |=> (st_ff == pcmr_pkg::ST_DIV && lat_lts_ff == $past(tdm_ts))
		##[1:20] st_ff == pcmr_pkg::ST_EVAL)
		else $error("packet not evaluated in time");
	a_ack_single: assert property (@(posedge mclk) disable iff (rst)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single cycle");
endmodule

/* File: pcmr_host_model.sv */
`timescale 1ns/1ps
// host software draining the event report queue, sometimes slowly
module pcmr_host_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// report handshake
	input wire logic rep_valid,
	output logic rep_ready
);
	// stall pattern source
	integer seed;

	initial begin
		seed = 32'h3A3C;
	end

	// one take per report, after a random stall of zero or more cycles
	always @(posedge mclk) begin
		if (rst) begin
			rep_ready <= 1'b0;
		end else if (rep_ready) begin
			rep_ready <= 1'b0;
		end else if (rep_valid) begin
			rep_ready <= (($random(seed) & 3) == 0);
		end
	end
endmodule

/* File: pcm_rx_event_report_bench.sv */
`timescale 1ns/1ps
// self-checking bench for the voice receive event reporter
module pcm_rx_event_report_bench;
	// expected report contents
	typedef struct {
		logic [12:0] fl;
		logic [31:0] lost;
		logic [31:0] rts;
		logic [31:0] lts;
	} pcmr_exp_t;
	// clock, reset and register bus
	logic mclk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	// packet, playout and report sides
	logic pkt_valid, pkt_ready, xdelay_det, wp_load, pkt_discard;
	logic rep_valid, rep_ready;
	logic [31:0] pkt_remote_ts, tdm_ts;
	logic [10:0] pkt_bytes;
	logic [7:0] pkt_chans;
	logic [3:0] pkt_bps;
	logic [11:0] tdm_rd_ptr, wp_value;
	logic [pcmr_pkg::FLAG_W-1:0] rep_flags;
	logic [31:0] rep_struct_addr, rep_lost, rep_remote_ts, rep_local_ts;
	// scoreboard
	pcmr_exp_t rep_q[$];
	logic [11:0] wp_q[$];
	logic [31:0] rd_q[$];
	pcmr_exp_t me;
	logic [31:0] sa;
	int err_total, checks, disc_exp, disc_seen, tno;
	integer seed;

	pcmr_event_report #(.BW(11), .PW(12)) pcmr_event_report_inst (
		.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
		.pkt_remote_ts(pkt_remote_ts), .pkt_bytes(pkt_bytes),
		.pkt_chans(pkt_chans), .pkt_bps(pkt_bps), .tdm_ts(tdm_ts),
		.tdm_rd_ptr(tdm_rd_ptr), .xdelay_det(xdelay_det),
		.wp_load(wp_load), .wp_value(wp_value), .pkt_discard(pkt_discard),
		.rep_valid(rep_valid), .rep_ready(rep_ready),
		.rep_flags(rep_flags), .rep_struct_addr(rep_struct_addr),
		.rep_lost(rep_lost), .rep_remote_ts(rep_remote_ts),
		.rep_local_ts(rep_local_ts));

	pcmr_host_model pcmr_host_model_inst (.mclk(mclk), .rst(rst),
		.rep_valid(rep_valid), .rep_ready(rep_ready));

	// 25 MHz clock
	always #20 mclk = ~mclk;

	// one comparison, counted
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask

	// counts and verdict, then stop
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// a wait that ran out
	task automatic lapse();
		chk("timeout", 32'h0, 32'h1);
		close_out();
	endtask

	// one classic wishbone cycle, held until ack
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] d);
		int n;
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) lapse();
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	// read with the expected word noted for the monitor
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		wb(1'b0, a, 4'hF, 32'h0);
	endtask

	// offer one packet; cb holds channels and bits per sample
	task automatic pkt(input logic [11:0] r, input logic [11:0] l,
		input logic [10:0] b, input logic [11:0] cb,
		input logic [12:0] fl, input logic [11:0] lost, input int wl);
		int n;
		logic [11:0] rp;
		rp = 12'($random(seed));
		if (fl != 13'h0000)
			rep_q.push_back(pcmr_exp_t'{fl, 32'(lost), 32'(r), 32'(l)});
		if (wl >= 0) wp_q.push_back(12'(wl) + rp);
		if (fl[8] || fl[10] || fl[11]) disc_exp++;
		@(posedge mclk);
		pkt_valid <= 1'b1;
		pkt_remote_ts <= 32'(r);
		tdm_ts <= 32'(l);
		pkt_bytes <= b;
		{pkt_chans, pkt_bps} <= cb;
		tdm_rd_ptr <= rp;
		xdelay_det <= fl[12];
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pkt_ready !== 1'b1 && n < 20);
		if (n >= 20) lapse();
		// playout values move on; the design must have kept its copy
		pkt_valid <= 1'b0;
		tdm_ts <= $random(seed);
		tdm_rd_ptr <= 12'($random(seed));
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pkt_ready !== 1'b1 && n < 300);
		if (n >= 300) lapse();
		xdelay_det <= 1'b0;
		tno++;
		$display("test %0d done", tno);
	endtask

	// monitor: takes the oldest note whenever a result appears
	always @(posedge mclk) begin
		if (!rst) begin
			if (rep_valid && rep_ready) begin
				if (rep_q.size() == 0) begin
					chk("report", 32'h0, 32'h1);
				end else begin
					me = rep_q.pop_front();
					chk("flags", 32'(me.fl), 32'(rep_flags));
					chk("lost", me.lost, rep_lost);
					chk("struct", sa, rep_struct_addr);
					chk("remote", me.rts, rep_remote_ts);
					chk("local", me.lts, rep_local_ts);
				end
			end
			if (wp_load) begin
				if (wp_q.size() == 0) chk("reload", 32'h0, 32'h1);
				else chk("reload", 32'(wp_q.pop_front()), 32'(wp_value));
			end
			if (pkt_discard) disc_seen++;
			if (wb_ack_o && !wb_we_i) begin
				if (rd_q.size() == 0) chk("read", 32'h0, 32'h1);
				else chk("read", rd_q.pop_front(), wb_dat_o);
			end
		end
	end

	// main sequence
	initial begin
		seed = 32'h3A3C;
		{mclk, wb_cyc_i, wb_stb_i, wb_we_i, pkt_valid, xdelay_det} = 6'h00;
		rst = 1'b1;
		{wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
		{pkt_remote_ts, tdm_ts, tdm_rd_ptr} = 76'h0;
		{pkt_bytes, pkt_chans, pkt_bps} = 23'h0;
		{err_total, checks, disc_exp, disc_seen, tno} = 160'h0;
		sa = $random(seed);
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		// reset values, set-up with split byte lanes, unmapped place
		rd(pcmr_pkg::OFS_LEADS, 32'h0000_0008);
		rd(pcmr_pkg::OFS_CTRL, 32'h0000_0000);
		wb(1'b1, pcmr_pkg::OFS_STRUCT, 4'hF, sa);
		wb(1'b1, pcmr_pkg::OFS_PAYLOAD, 4'hF, 32'h0064_0004);
		wb(1'b1, pcmr_pkg::OFS_LEADS, 4'h3, 32'hFFFF_0008);
		wb(1'b1, pcmr_pkg::OFS_LEADS, 4'hC, 32'h0014_FFFF);
		wb(1'b1, pcmr_pkg::OFS_INIT_LEAD, 4'hF, 32'h0000_0005);
		rd(pcmr_pkg::OFS_LEADS, 32'h0014_0008);
		rd(8'h20, 32'h0000_0000);
		// first packet, then requests completed by later packets
		pkt(12'h000, 12'h000, 11'h004, 12'h018, 13'h0018, 12'h0, 5);
		rd(pcmr_pkg::OFS_CTRL, 32'h0000_000C);
		wb(1'b1, pcmr_pkg::OFS_CTRL, 4'hF, 32'h0000_000D);
		pkt(12'h004, 12'h000, 11'h004, 12'h018, 13'h0020, 12'h0, -1);
		rd(pcmr_pkg::OFS_CTRL, 32'h0000_000C);
		rd(pcmr_pkg::OFS_DELTA, 32'h0004_0004);
		wb(1'b1, pcmr_pkg::OFS_CTRL, 4'hF, 32'h0000_000E);
		pkt(12'h008, 12'h000, 11'h004, 12'h018, 13'h0040, 12'h0, -1);
		pkt(12'h00C, 12'h000, 11'h004, 12'h018, 13'h0000, 12'h0, -1);
		// gap, long packet, late, underrun, overrun, extreme delay
		pkt(12'h014, 12'h00A, 11'h006, 12'h018, 13'h0280, 12'h4, -1);
		pkt(12'h01A, 12'h01E, 11'h004, 12'h018, 13'h0003, 12'h0, 8);
		pkt(12'h01E, 12'h01E, 11'h002, 12'h018, 13'h0002, 12'h0, 8);
		pkt(12'h0E8, 12'h000, 11'h004, 12'h018, 13'h0084, 12'hC8, 20);
		pkt(12'h0EC, 12'h0E2, 11'h004, 12'h018, 13'h1000, 12'h0, -1);
		// length errors leave the channel state alone
		pkt(12'h0F0, 12'h0E6, 11'h003, 12'h028, 13'h0100, 12'h0, -1);
		pkt(12'h0F0, 12'h0E6, 11'h000, 12'h018, 13'h0800, 12'h0, -1);
		wb(1'b1, pcmr_pkg::OFS_PAYLOAD, 4'hF, 32'hFFFF_0004);
		pkt(12'h0F0, 12'h0E6, 11'h7FF, 12'h014, 13'h0600, 12'h0, -1);
		pkt(12'h0F0, 12'h0E6, 11'h004, 12'h018, 13'h0000, 12'h0, -1);
		repeat (4) @(posedge mclk);
		chk("discards", 32'(disc_exp), 32'(disc_seen));
		chk("reports left", 32'h0, 32'(rep_q.size()));
		chk("reloads left", 32'h0, 32'(wp_q.size()));
		close_out();
	end
endmodule
